/* calendar_clock_consts.vh */
// Constants for the calendar clock with its AXI4-Lite register tables.
// Assumes a single 10 MHz clock and a synchronous active-high reset.
`ifndef CALENDAR_CLOCK_CONSTS_VH
`define CALENDAR_CLOCK_CONSTS_VH

// Table numbers; byte address is four times the number
`define IDX_SEC        10'd247
`define IDX_MIN        10'd248
`define IDX_HOUR       10'd249
`define IDX_DATE       10'd250
`define IDX_MONTH      10'd251
`define IDX_YEAR       10'd252
`define IDX_DOW        10'd253
`define IDX_TIME_SET   10'd254
`define IDX_DATE_SET   10'd255
`define ADDR_W         12

// Byte lanes of the setting words
`define LANE0_LSB      0
`define LANE1_LSB      8
`define LANE2_LSB      16
`define LANE3_LSB      24

// Values after reset
`define RST_SEC        8'h00
`define RST_MIN        8'h00
`define RST_HOUR       8'h00
`define RST_DATE       8'h01
`define RST_MONTH      8'h01
`define RST_YEAR       8'h00
`define RST_DOW        8'h00

// BCD limits
`define SEC_LAST       8'h59
`define MIN_LAST       8'h59
`define HOUR_LAST      8'h23
`define MONTH_LAST     8'h12
`define YEAR_LAST      8'h99
`define DOW_LAST       8'h06
`define DATE_FIRST     8'h01
`define MONTH_FIRST    8'h01
`define DAYS_31        8'h31
`define DAYS_30        8'h30
`define DAYS_29        8'h29
`define DAYS_28        8'h28
`define MON_FEB        8'h02
`define MON_APR        8'h04
`define MON_JUN        8'h06
`define MON_SEP        8'h09
`define MON_NOV        8'h11
`define DIGIT_NINE     4'h9

// Tick timing
`define CLK_PERIOD_NS  100
`define TICK_PERIOD_NS 1000000000

// AXI responses
`define RESP_OKAY      2'b00
`define RESP_SLVERR    2'b10

`endif

/* one_second_tick.v */
// One-second tick generator for the calendar clock.
// Assumes the caller sets CYCLES to clock cycles per second.
`timescale 1ns/10ps
module one_second_tick #(
  parameter CYCLES = 10000000,
  parameter CNT_W  = 24
) (
  input  wire ref_clk_in,
  input  wire rst_in,
  output reg  tick_out
);
  localparam [CNT_W-1:0] LAST = CYCLES - 1;
  localparam [CNT_W-1:0] ONE  = 1;
  reg [CNT_W-1:0] count;

  // Free-running divider, one pulse per wrap
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      count    <= {CNT_W{1'b0}};
      tick_out <= 1'b0;
    end else if (count == LAST) begin
      count    <= {CNT_W{1'b0}};
      tick_out <= 1'b1;
    end else begin
      count    <= count + ONE;
      tick_out <= 1'b0;
    end
  end
endmodule // one_second_tick

/* calendar_clock_tables.v */
// Calendar clock: BCD time of day and date behind an AXI4-Lite slave.
// Assumes a master that keeps one write and one read in flight at most.
//
// The register offsets and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "calendar_clock_consts.vh"
module calendar_clock_tables #(
  parameter TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS
) (
  input  wire                ref_clk_in,
  input  wire                rst_in,
  input  wire [`ADDR_W-1:0]  s_axi_awaddr_in,
  input  wire                s_axi_awvalid_in,
  output reg                 s_axi_awready_out,
  input  wire [31:0]         s_axi_wdata_in,
  input  wire [3:0]          s_axi_wstrb_in,
  input  wire                s_axi_wvalid_in,
  output reg                 s_axi_wready_out,
  output reg  [1:0]          s_axi_bresp_out,
  output reg                 s_axi_bvalid_out,
  input  wire                s_axi_bready_in,
  input  wire [`ADDR_W-1:0]  s_axi_araddr_in,
  input  wire                s_axi_arvalid_in,
  output reg                 s_axi_arready_out,
  output reg  [31:0]         s_axi_rdata_out,
  output reg  [1:0]          s_axi_rresp_out,
  output reg                 s_axi_rvalid_out,
  input  wire                s_axi_rready_in
);
  reg  [7:0]         sec;
  reg  [7:0]         min;
  reg  [7:0]         hour;
  reg  [7:0]         date;
  reg  [7:0]         month;
  reg  [7:0]         year;
  reg  [7:0]         dow;
  reg  [7:0]         next_sec;
  reg  [7:0]         next_min;
  reg  [7:0]         next_hour;
  reg  [7:0]         next_date;
  reg  [7:0]         next_month;
  reg  [7:0]         next_year;
  reg  [7:0]         next_dow;
  reg  [`ADDR_W-1:0] wr_addr;
  reg  [31:0]        wr_data;
  reg  [3:0]         wr_strb;
  wire               tick;
  wire [9:0]         wr_idx;
  wire               wr_go;
  wire [32:0]        wr_view;
  wire [32:0]        rd_view;

  assign wr_idx = wr_addr[`ADDR_W-1:2];
  // Table views; the top bit says the address hits the clock tables
  assign wr_view = read_word(wr_idx);
  assign rd_view = read_word(s_axi_araddr_in[`ADDR_W-1:2]);
  // Both halves of the write held and no answer pending
  assign wr_go  = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;

  // BCD increment of a two-digit field
  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == `DIGIT_NINE)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // Last date of a month; two-digit years divisible by four are leap
  function [7:0] month_last;
    input [7:0] m;
    input [7:0] y;
    reg leap;
    begin
      leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                  : (y[3:0] == 4'h0 || y[3:0] == 4'h4 ||
                     y[3:0] == 4'h8);
      case (m)
        `MON_FEB: month_last = leap ? `DAYS_29 : `DAYS_28;
        `MON_APR, `MON_JUN, `MON_SEP, `MON_NOV: month_last = `DAYS_30;
        default: month_last = `DAYS_31;
      endcase
    end
  endfunction

  // Byte-lane merge of a write into a field
  function [7:0] lane_merge;
    input [7:0] old;
    input [7:0] new_v;
    input       en;
    begin
      lane_merge = en ? new_v : old;
    end
  endfunction

  // Read view of the tables; setting words read as zero
  function [32:0] read_word;
    input [9:0] idx;
    begin
      case (idx)
        `IDX_SEC:      read_word = {1'b1, 24'h000000, sec};
        `IDX_MIN:      read_word = {1'b1, 24'h000000, min};
        `IDX_HOUR:     read_word = {1'b1, 24'h000000, hour};
        `IDX_DATE:     read_word = {1'b1, 24'h000000, date};
        `IDX_MONTH:    read_word = {1'b1, 24'h000000, month};
        `IDX_YEAR:     read_word = {1'b1, 24'h000000, year};
        `IDX_DOW:      read_word = {1'b1, 24'h000000, dow};
        `IDX_TIME_SET: read_word = {1'b1, 32'h00000000};
        `IDX_DATE_SET: read_word = {1'b1, 32'h00000000};
        default:       read_word = {1'b0, 32'h00000000};
      endcase
    end
  endfunction

  one_second_tick #(
    .CYCLES (TICK_CYCLES),
    .CNT_W  (24)
  ) u_tick (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .tick_out   (tick)
  );

  // Calendar advance and setting loads; a host setting wins over the tick
  always @* begin
    next_sec   = sec;
    next_min   = min;
    next_hour  = hour;
    next_date  = date;
    next_month = month;
    next_year  = year;
    next_dow   = dow;
    if (wr_go && wr_idx == `IDX_TIME_SET) begin
      next_sec  = lane_merge(sec, wr_data[`LANE0_LSB +: 8],
                             wr_strb[0]);
      next_min  = lane_merge(min, wr_data[`LANE1_LSB +: 8],
                             wr_strb[1]);
      next_hour = lane_merge(hour, wr_data[`LANE2_LSB +: 8],
                             wr_strb[2]);
      next_date = lane_merge(date, wr_data[`LANE3_LSB +: 8],
                             wr_strb[3]);
    end else if (wr_go && wr_idx == `IDX_DATE_SET) begin
      // Top byte is vacant and never read back
      next_month = lane_merge(month, wr_data[`LANE0_LSB +: 8],
                              wr_strb[0]);
      next_year  = lane_merge(year, wr_data[`LANE1_LSB +: 8],
                              wr_strb[1]);
      next_dow   = lane_merge(dow, wr_data[`LANE2_LSB +: 8],
                              wr_strb[2]);
    end else if (tick) begin
      if (sec != `SEC_LAST) begin
        next_sec = bcd_inc(sec);
      end else begin
        next_sec = `RST_SEC;
        if (min != `MIN_LAST) begin
          next_min = bcd_inc(min);
        end else begin
          next_min = `RST_MIN;
          if (hour != `HOUR_LAST) begin
            next_hour = bcd_inc(hour);
          end else begin
            next_hour = `RST_HOUR;
            // Weekday wraps from Saturday back to Sunday
            next_dow = (dow == `DOW_LAST) ? `RST_DOW : bcd_inc(dow);
            if (date < month_last(month, year)) begin
              next_date = bcd_inc(date);
            end else begin
              next_date = `DATE_FIRST;
              if (month != `MONTH_LAST) begin
                next_month = bcd_inc(month);
              end else begin
                next_month = `MONTH_FIRST;
                next_year  = (year == `YEAR_LAST) ? `RST_YEAR
                                                  : bcd_inc(year);
              end
            end
          end
        end
      end
    end
  end

  // Time registers; reset gives a fixed start, no preset contents
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      sec   <= `RST_SEC;
      min   <= `RST_MIN;
      hour  <= `RST_HOUR;
      date  <= `RST_DATE;
      month <= `RST_MONTH;
      year  <= `RST_YEAR;
      dow   <= `RST_DOW;
    end else begin
      sec   <= next_sec;
      min   <= next_min;
      hour  <= next_hour;
      date  <= next_date;
      month <= next_month;
      year  <= next_year;
      dow   <= next_dow;
    end
  end

  // Write channels: address and data taken in either order, then answered
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `RESP_OKAY;
      wr_addr           <= {`ADDR_W{1'b0}};
      wr_data           <= 32'h00000000;
      wr_strb           <= 4'h0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        wr_addr           <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        wr_data          <= s_axi_wdata_in;
        wr_strb          <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid_out <= 1'b1;
        // Display tables accept and drop writes; outside space is an error
        s_axi_bresp_out  <= wr_view[32] ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // Read channel: data sampled at the address handshake
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= rd_view[31:0];
      s_axi_rresp_out   <= rd_view[32] ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end
endmodule // calendar_clock_tables

/* calendar_clock_checker.sv */
// Checker: bus answer timing and table map of the calendar clock.
// Assumes a bind to calendar_clock_tables; it sees only that module's ports.
`timescale 1ns/10ps
`include "calendar_clock_consts.vh"
module calendar_clock_checker #(
  parameter TICK_CYCLES = 100
) (
  input wire        ref_clk_in,
  input wire        rst_in,
  input wire [11:0] s_axi_awaddr_in,
  input wire        s_axi_awvalid_in,
  input wire        s_axi_awready_out,
  input wire        s_axi_wvalid_in,
  input wire        s_axi_wready_out,
  input wire [1:0]  s_axi_bresp_out,
  input wire        s_axi_bvalid_out,
  input wire [11:0] s_axi_araddr_in,
  input wire        s_axi_arvalid_in,
  input wire        s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire [1:0]  s_axi_rresp_out,
  input wire        s_axi_rvalid_out
);
  // Handshakes and table numbers; write timing is only judged when
  // address and data are taken at one edge, the usual case
  wire       ar_hs = s_axi_arvalid_in && s_axi_arready_out;
  wire       wr_hs = s_axi_awvalid_in && s_axi_awready_out &&
                     s_axi_wvalid_in && s_axi_wready_out;
  wire [9:0] ridx  = s_axi_araddr_in[11:2];
  wire [9:0] widx  = s_axi_awaddr_in[11:2];
  wire       rmap  = ridx >= `IDX_SEC && ridx <= `IDX_DATE_SET;
  wire       wmap  = widx >= `IDX_SEC && widx <= `IDX_DATE_SET;
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  AST_RD_ANSWER: assert property (
    ar_hs |=> s_axi_rvalid_out && !s_axi_arready_out)
    else $error("read answer missing");
  AST_WR_ANSWER: assert property (
    wr_hs |=> !s_axi_bvalid_out ##1 s_axi_bvalid_out)
    else $error("write answer not two edges later");
  AST_B_BLOCKS: assert property (
    s_axi_bvalid_out |-> !s_axi_awready_out && !s_axi_wready_out)
    else $error("new write taken before response");
  AST_RD_UNMAPPED: assert property (
    ar_hs && !rmap |=> s_axi_rresp_out == `RESP_SLVERR &&
    s_axi_rdata_out == 32'h0)
    else $error("unmapped read not refused");
  AST_WR_UNMAPPED: assert property (
    wr_hs && !wmap |=> ##1 s_axi_bresp_out == `RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_RD_MAPPED: assert property (
    ar_hs && rmap |=> s_axi_rresp_out == `RESP_OKAY)
    else $error("clock table read refused");
  AST_SET_READ: assert property (
    ar_hs && rmap && ridx >= `IDX_TIME_SET |=> s_axi_rdata_out == 32'h0)
    else $error("setting word read not zero");
  AST_DISP_BCD: assert property (
    ar_hs && ridx >= `IDX_SEC && ridx <= `IDX_DOW |=>
    s_axi_rdata_out[31:8] == 24'h0 && s_axi_rdata_out[3:0] <= `DIGIT_NINE)
    else $error("display value not one BCD byte");
  AST_DOW_RANGE: assert property (
    ar_hs && ridx == `IDX_DOW |=> s_axi_rdata_out[7:0] <= `DOW_LAST)
    else $error("weekday out of range");
  AST_SEC_RANGE: assert property (
    ar_hs && ridx == `IDX_SEC |=> s_axi_rdata_out[7:0] <= `SEC_LAST)
    else $error("second out of range");

  // Main scenarios
  COV_WRITE: cover property (wr_hs);
  COV_UNMAPPED: cover property (ar_hs && !rmap);
  COV_SET_READ: cover property (ar_hs && ridx == `IDX_DATE_SET);
endmodule // calendar_clock_checker

bind calendar_clock_tables calendar_clock_checker #(
  .TICK_CYCLES(TICK_CYCLES)) u_chk (.ref_clk_in, .rst_in,
  .s_axi_awaddr_in, .s_axi_awvalid_in, .s_axi_awready_out,
  .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out,
  .s_axi_bvalid_out, .s_axi_araddr_in, .s_axi_arvalid_in,
  .s_axi_arready_out, .s_axi_rdata_out, .s_axi_rresp_out,
  .s_axi_rvalid_out);

/* host_model.sv */
// Host controller model: bus master that loads and copies clock tables.
// Assumes its tasks are called one at a time, each after a clock edge.
`timescale 1ns/10ps
module host_model (
  input  wire        ref_clk_in,
  output reg  [11:0] awaddr_out,
  output reg         awvalid_out,
  input  wire        awready_in,
  output reg  [31:0] wdata_out,
  output reg  [3:0]  wstrb_out,
  output reg         wvalid_out,
  input  wire        wready_in,
  input  wire        bvalid_in,
  output reg         bready_out,
  output reg  [11:0] araddr_out,
  output reg         arvalid_out,
  input  wire        arready_in,
  input  wire [31:0] rdata_in,
  input  wire        rvalid_in,
  output reg         rready_out
);
  // Bus idle from time zero
  initial begin
    {awvalid_out, wvalid_out, bready_out, arvalid_out, rready_out} = 5'h00;
    {awaddr_out, araddr_out, wdata_out, wstrb_out} = 60'h0;
  end

  // Load a table; released address and data are inverted so no stale value lingers on them
  task write(input [11:0] a, input [31:0] d, input [3:0] s);
    @(posedge ref_clk_in);
    awaddr_out <= a;
    wdata_out <= d;
    wstrb_out <= s;
    {awvalid_out, wvalid_out, bready_out} <= 3'h7;
    do begin
      @(posedge ref_clk_in);
      if (awvalid_out && awready_in) begin
        awvalid_out <= 1'b0;
        awaddr_out <= ~a;
      end
      if (wvalid_out && wready_in) begin
        wvalid_out <= 1'b0;
        wdata_out <= ~d;
      end
    end while (awvalid_out || wvalid_out);
    while (!bvalid_in) @(posedge ref_clk_in);
    bready_out <= 1'b0;
  endtask

  // Copy one table out
  task read(input [11:0] a, output [31:0] d);
    @(posedge ref_clk_in);
    araddr_out <= a;
    {arvalid_out, rready_out} <= 2'h3;
    do @(posedge ref_clk_in); while (!arready_in);
    arvalid_out <= 1'b0;
    araddr_out <= ~a;
    do @(posedge ref_clk_in); while (!rvalid_in);
    d = rdata_in;
    rready_out <= 1'b0;
  endtask
endmodule // host_model

/* calendar_clock_tables_tb.sv */
// Testbench: host model drives the clock tables, a monitor scores answers.
// Assumes a short second of 100 clocks so calendar carries run quickly.
`timescale 1ns/10ps
`include "calendar_clock_consts.vh"
`define CHECK_EQ(g, e) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("mismatch at %0t: got %h exp %h", $time, g, e); end end
module calendar_clock_tables_tb;
  logic        ref_clk_in, rst_in;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, bnote;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  y;
  logic [67:0] rnote, rq[$];
  logic [1:0]  bq[$];
  int          error_cnt = 0;
  int          num_checks = 0;

  calendar_clock_tables #(.TICK_CYCLES(100)) dut (.ref_clk_in, .rst_in,
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready));
  host_model host (.ref_clk_in, .awaddr_out(awaddr), .awvalid_out(awvalid),
    .awready_in(awready), .wdata_out(wdata), .wstrb_out(wstrb),
    .wvalid_out(wvalid), .wready_in(wready), .bvalid_in(bvalid),
    .bready_out(bready), .araddr_out(araddr), .arvalid_out(arvalid),
    .arready_in(arready), .rdata_in(rdata), .rvalid_in(rvalid),
    .rready_out(rready));

  // 10 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end

  // Monitor: each answer is matched against the oldest note, read answers masked
  always @(posedge ref_clk_in) begin
    if (rvalid && rready) begin
      rnote = rq.pop_front();
      `CHECK_EQ({rresp, rdata} & rnote[67:34], rnote[33:0])
    end
    if (bvalid && bready) begin
      bnote = bq.pop_front();
      `CHECK_EQ(bresp, bnote)
    end
  end

  task automatic rd(input logic [9:0] idx, input logic [31:0] exp,
    input logic [1:0] resp = `RESP_OKAY, input logic [31:0] m = '1);
    rq.push_back({2'b11, m, resp, exp & m});
    host.read({idx, 2'b00}, v);
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d,
    input logic [3:0] s = 4'hf, input logic [1:0] resp = `RESP_OKAY);
    bq.push_back(resp);
    host.write({idx, 2'b00}, d, s);
  endtask

  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Main sequence; the first tick lands 100 clocks after reset
  initial begin
    rst_in = 1'b1;
    v = $urandom(32'hce0fbbb1);
    repeat (20) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    for (int i = 247; i <= 253; i++) wr(10'(i), $urandom);
    rd(`IDX_SEC, 0);
    rd(`IDX_MIN, 0);
    rd(`IDX_HOUR, 0);
    rd(`IDX_DATE, 1);
    rd(`IDX_MONTH, 1);
    rd(`IDX_YEAR, 0);
    rd(`IDX_DOW, 0);
    $display("test done: reset view");
    rd(10'd246, 0, `RESP_SLVERR);
    rd(10'h100, 0, `RESP_SLVERR);
    rd(10'($urandom % 247), 0, `RESP_SLVERR);
    wr(10'h100, $urandom, 4'hf, `RESP_SLVERR);
    rd(`IDX_TIME_SET, 0);
    rd(`IDX_DATE_SET, 0);
    $display("test done: map");
    for (int d = 0; d <= 6; d++) begin
      y = {4'($urandom % 10), 4'($urandom % 10)};
      wr(`IDX_DATE_SET, {8'h00, d[7:0], y, 8'h12});
      rd(`IDX_DOW, d);
      rd(`IDX_YEAR, y);
      rd(`IDX_MONTH, 32'h12);
    end
    wr(`IDX_DATE_SET, 32'h00057709, 4'b0010);
    rd(`IDX_YEAR, 32'h77);
    rd(`IDX_MONTH, 32'h12);
    rd(`IDX_DOW, 6);
    wr(`IDX_TIME_SET, 32'h17214530);
    rd(`IDX_MIN, 32'h45);
    rd(`IDX_HOUR, 32'h21);
    rd(`IDX_DATE, 32'h17);
    $display("test done: setting words");
    // Midnight on 28 February, common year then leap year
    for (int k = 0; k < 2; k++) begin
      wr(`IDX_DATE_SET, {16'h0006, k ? 8'h04 : 8'h01, 8'h02});
      wr(`IDX_TIME_SET, 32'h28235959);
      do rd(`IDX_SEC, 0, `RESP_OKAY, 0); while (v[7:0] !== 8'h00);
      rd(`IDX_MIN, 0);
      rd(`IDX_HOUR, 0);
      rd(`IDX_DOW, 0);
      rd(`IDX_DATE, k ? 32'h29 : 32'h01);
      rd(`IDX_YEAR, k ? 4 : 1);
      rd(`IDX_MONTH, k ? 32'h02 : 32'h03);
    end
    $display("test done: rollover");
    repeat (3) @(posedge ref_clk_in);
    end_of_test;
  end

  // Watchdog, well beyond the expected run length
  initial begin
    repeat (20000) @(posedge ref_clk_in);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    end_of_test;
  end
endmodule // calendar_clock_tables_tb
